// [hw/packet_link_access_control.v]
// access, timing and line-editing control for a packet radio link controller
// Operation
// - keying waits key-up delay before data
// - programmable slot time, default 10
// - transmit disabled never keys transmitter
// - connection channels capped, default four
// - channel zero only for broadcast
// - two-bit handshake mode, one bit per direction
// - acknowledgement delayed by ack timer
// - silent station polled after idle interval
// - greeting sent on connect when nonzero
// - mode two: line starting //Q disconnects in terminal mode
// - character width seven or eight bits
// - three smoothing constants, defaults 7,15,3
// - poll frame length, default 60
// - station identifier check switch
// - backspace deletes, ctrl-U/X drops line
// - ctrl-R hides line, again restores
// - mute transmit while receiving, strap overrides
// - test mode sends only zeros
// - transmit time limiter, strap disables
// - shared carrier low means channel busy
// - own signal pulls shared carrier low
// - persistence (n+1)/256, 255 under demand access
`timescale 1ns/100ps
`default_nettype none
`include "link_access_regs.vh"
module packet_link_access_control #(
	parameter TICK_CYCLES = `TICK_CYCLES
) (
	input  wire       clk,
	input  wire       rstn,
	input  wire       clk_en,
	input  wire       cmd_valid,
	input  wire [3:0] cmd_sel,
	input  wire [15:0] cmd_data,
	input  wire       tx_request,
	input  wire       rx_packet_done,
	input  wire       remote_activity,
	input  wire       remote_connect,
	input  wire       terminal_mode,
	input  wire       term_char_valid,
	input  wire [7:0] term_char,
	input  wire       own_signal_detect,
	input  wire       shared_dcd_n_in,
	input  wire       rx_active,
	input  wire       mute_off_strap,
	input  wire       bit_error_test,
	input  wire       limit_off_strap,
	input  wire       demand_assigned_access,
	input  wire       data_bit,
	input  wire [7:0] random_byte,
	input  wire [3:0] channel_select,
	output reg        ptt_r,
	output reg        tx_data_ok_r,
	output reg        tx_bit_r,
	output reg        shared_dcd_oe_r,
	output reg        shared_dcd_out_r,
	output reg        carrier_led_r,
	output reg        ack_send_r,
	output reg        status_poll_r,
	output reg        greeting_send_r,
	output reg        disconnect_r,
	output reg        limit_trip_r,
	output reg        chan_ok_r,
	output reg [6:0]  key_up_delay_r,
	output reg [6:0]  slot_time_r,
	output reg [3:0]  max_link_channels_r,
	output reg [1:0]  handshake_r,
	output reg        xon_to_term_r,
	output reg        xon_to_ctrl_r,
	output reg [15:0] ack_delay_timer_r,
	output reg [14:0] link_idle_timer_r,
	output reg [1:0]  greeting_mode_r,
	output reg        char_width_8_r,
	output reg [7:0]  rtt_weight_one_r,
	output reg [7:0]  rtt_weight_two_r,
	output reg [7:0]  rtt_weight_three_r,
	output reg [7:0]  poll_frame_len_r,
	output reg        id_check_r,
	output reg        xmit_enable_r,
	output reg [7:0]  persistence_value_r,
	output reg [6:0]  line_len_r,
	output reg        line_hidden_r,
	output reg        line_clear_r
);

	// ==========================================================
	// tick and access state
	localparam ST_IDLE = 2'h0;
	localparam ST_SLOT = 2'h1;
	localparam ST_KEYUP = 2'h2;
	localparam ST_SEND = 2'h3;

	reg [31:0] tick_cnt_r;
	reg        tick_r;
	reg [1:0]  st_r;
	reg [6:0]  wait_r;
	reg [15:0] key_time_r;
	reg [15:0] ack_cnt_r;
	reg        ack_run_r;
	reg [14:0] idle_cnt_r;
	reg [6:0]  hidden_len_r;
	reg [1:0]  quit_r;

	// external carrier or our own keeps the channel occupied
	wire       busy = ~shared_dcd_n_in | own_signal_detect;
	wire       tx_mute = rx_active & ~mute_off_strap;
	wire [7:0] persist_eff = demand_assigned_access ? `PERSIST_DEMAND_ASSIGNED_ACCESS : persistence_value_r;

	// ==========================================================
	// one tick every 10 ms shared by every timer
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tick_cnt_r <= 32'h0;
			tick_r <= 1'b0;
		end else if (clk_en) begin
			tick_r <= (tick_cnt_r == TICK_CYCLES - 1);
			tick_cnt_r <= (tick_cnt_r == TICK_CYCLES - 1) ? 32'h0 : tick_cnt_r + 32'h1;
		end
	end

	// ==========================================================
	// configuration commands from the terminal side
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			key_up_delay_r <= `KEY_UP_DELAY_RST;
			slot_time_r <= `SLOT_TIME_RST;
			xmit_enable_r <= 1'b1;
			max_link_channels_r <= `MAX_LINK_CHAN_RST;
			handshake_r <= `HANDSHAKE_RST;
			ack_delay_timer_r <= `ACK_DELAY_RST;
			link_idle_timer_r <= `LINK_IDLE_RST;
			greeting_mode_r <= `GREETING_RST;
			char_width_8_r <= `CHAR_WIDTH_RST;
			rtt_weight_one_r <= `RTT_WEIGHT_ONE_RST;
			rtt_weight_two_r <= `RTT_WEIGHT_TWO_RST;
			rtt_weight_three_r <= `RTT_WEIGHT_THREE_RST;
			poll_frame_len_r <= `POLL_LEN_RST;
			id_check_r <= 1'b0;
			persistence_value_r <= `PERSIST_RST;
		end else if (clk_en && cmd_valid) begin
			case (cmd_sel)
			`CMD_KEY_UP: key_up_delay_r <= cmd_data[6:0];
			`CMD_SLOT: slot_time_r <= cmd_data[6:0];
			`CMD_XMIT_EN: xmit_enable_r <= cmd_data[0];
			`CMD_MAX_CHAN: begin
				// values beyond the channel table are clamped
				max_link_channels_r <= (cmd_data[3:0] > `MAX_LINK_CHAN_LIM) ?
					`MAX_LINK_CHAN_LIM : cmd_data[3:0];
			end
			`CMD_HANDSHAKE: handshake_r <= cmd_data[1:0];
			`CMD_ACK_DELAY: ack_delay_timer_r <= cmd_data;
			`CMD_LINK_IDLE: link_idle_timer_r <= cmd_data[14:0];
			`CMD_GREETING: greeting_mode_r <= cmd_data[1:0];
			`CMD_CHAR_WIDTH: char_width_8_r <= cmd_data[0];
			`CMD_RTT_ONE: rtt_weight_one_r <= cmd_data[7:0];
			`CMD_RTT_TWO: rtt_weight_two_r <= cmd_data[7:0];
			`CMD_RTT_THREE: rtt_weight_three_r <= cmd_data[7:0];
			`CMD_POLL_LEN: poll_frame_len_r <= cmd_data[7:0];
			`CMD_ID_CHECK: id_check_r <= cmd_data[0];
			`CMD_PERSIST: persistence_value_r <= cmd_data[7:0];
			default: ;
			endcase
		end
	end

	// ==========================================================
	// channel access: slot wait, persistence draw, key-up, send
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st_r <= ST_IDLE;
			wait_r <= 7'h0;
			key_time_r <= 16'h0;
			ptt_r <= 1'b0;
			tx_data_ok_r <= 1'b0;
			limit_trip_r <= 1'b0;
		end else if (clk_en) begin
			if (!tx_request) limit_trip_r <= 1'b0; // a trip set below wins over this clear
			// keying drops at once if disabled, muted, no longer requested, or busy before sending starts
			if (!xmit_enable_r || tx_mute || (busy && st_r != ST_SEND) ||
				(!tx_request && st_r != ST_IDLE)) begin
				st_r <= ST_IDLE;
				key_time_r <= 16'h0;
				ptt_r <= 1'b0;
				tx_data_ok_r <= 1'b0;
			end else begin
				case (st_r)
				ST_IDLE: begin
					key_time_r <= 16'h0;
					if (tx_request && !limit_trip_r) begin
						st_r <= ST_SLOT;
						wait_r <= slot_time_r;
					end
				end
				ST_SLOT: begin
					if (wait_r != 7'h0) begin
						if (tick_r) wait_r <= wait_r - 7'h1;
					end else if (random_byte <= persist_eff) begin
						st_r <= ST_KEYUP;
						ptt_r <= 1'b1;
						wait_r <= key_up_delay_r;
					end else begin
						wait_r <= slot_time_r;
					end
				end
				ST_KEYUP: begin
					if (wait_r == 7'h0) begin
						st_r <= ST_SEND;
						tx_data_ok_r <= 1'b1;
					end else if (tick_r) begin
						wait_r <= wait_r - 7'h1;
					end
				end
				default: ; // sending holds until the request drops
				endcase
				// stuck keying is cut; trip stays until keying request drops
				if (ptt_r && tick_r) key_time_r <= key_time_r + 16'h1;
				if (!limit_off_strap && key_time_r >= `TX_LIMIT_TICKS) begin
					limit_trip_r <= 1'b1;
					st_r <= ST_IDLE;
					ptt_r <= 1'b0;
					tx_data_ok_r <= 1'b0;
				end
			end
		end
	end

	// ==========================================================
	// data path, carrier sharing and channel check
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tx_bit_r <= 1'b0;
			shared_dcd_oe_r <= 1'b0;
			shared_dcd_out_r <= 1'b0;
			carrier_led_r <= 1'b0;
			chan_ok_r <= 1'b0;
			xon_to_term_r <= 1'b0;
			xon_to_ctrl_r <= 1'b0;
		end else if (clk_en) begin
			tx_bit_r <= bit_error_test ? 1'b0 : data_bit;
			shared_dcd_oe_r <= own_signal_detect;
			carrier_led_r <= busy;
			chan_ok_r <= (channel_select != 4'h0) &&
				(channel_select <= max_link_channels_r);
			xon_to_term_r <= handshake_r[1];
			xon_to_ctrl_r <= handshake_r[0];
		end
	end

	// ==========================================================
	// acknowledgement and idle-link timers
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ack_cnt_r <= 16'h0;
			ack_run_r <= 1'b0;
			ack_send_r <= 1'b0;
			idle_cnt_r <= 15'h0;
			status_poll_r <= 1'b0;
			greeting_send_r <= 1'b0;
		end else if (clk_en) begin
			ack_send_r <= 1'b0;
			status_poll_r <= 1'b0;
			greeting_send_r <= remote_connect && (greeting_mode_r != 2'h0);
			if (rx_packet_done) begin
				ack_run_r <= 1'b1;
				ack_cnt_r <= 16'h0;
			end else if (ack_run_r && ack_cnt_r >= ack_delay_timer_r) begin
				ack_run_r <= 1'b0;
				ack_send_r <= 1'b1;
			end else if (ack_run_r && tick_r) begin
				ack_cnt_r <= ack_cnt_r + 16'h1;
			end
			if (remote_activity) begin
				idle_cnt_r <= 15'h0;
			end else if (idle_cnt_r >= link_idle_timer_r) begin
				idle_cnt_r <= 15'h0;
				status_poll_r <= 1'b1;
			end else if (tick_r) begin
				idle_cnt_r <= idle_cnt_r + 15'h1;
			end
		end
	end

	// ==========================================================
	// line editor: length tracking, hide/restore, quit detection
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			line_len_r <= 7'h0;
			hidden_len_r <= 7'h0;
			line_hidden_r <= 1'b0;
			line_clear_r <= 1'b0;
			quit_r <= 2'h0;
			disconnect_r <= 1'b0;
		end else if (clk_en) begin
			line_clear_r <= 1'b0;
			disconnect_r <= 1'b0;
			if (term_char_valid) begin
				case (char_width_8_r ? term_char : {1'b0, term_char[6:0]})
				8'h08, 8'h7F: if (line_len_r != 7'h0) line_len_r <= line_len_r - 7'h1;
				8'h15, 8'h18: begin
					line_len_r <= 7'h0;
					line_clear_r <= 1'b1;
				end
				8'h12: begin
					// hidden length is kept so the line returns unchanged
					line_hidden_r <= ~line_hidden_r;
					if (!line_hidden_r) begin
						hidden_len_r <= line_len_r;
						line_len_r <= 7'h0;
					end else begin
						line_len_r <= hidden_len_r;
					end
				end
				8'h0D: begin
					line_len_r <= 7'h0;
					quit_r <= 2'h0;
				end
				default: begin
					if (line_len_r < `LINE_MAX) line_len_r <= line_len_r + 7'h1;
					if (line_len_r == 7'h0 && term_char[6:0] == 7'h2F) quit_r <= 2'h1;
					else if (quit_r == 2'h1 && line_len_r == 7'h1 && term_char[6:0] == 7'h2F)
						quit_r <= 2'h2;
					else if (quit_r == 2'h2 && line_len_r == 7'h2 &&
						(term_char[6:0] == 7'h51 || term_char[6:0] == 7'h71)) begin
						quit_r <= 2'h0;
						disconnect_r <= (greeting_mode_r == 2'h2) && terminal_mode;
					end else quit_r <= 2'h0;
				end
				endcase
			end
		end
	end

endmodule
`default_nettype wire

// [hw/link_access_regs.vh]
// timing constants and reset values for the packet link access controller
`ifndef LINK_ACCESS_REGS_VH
`define LINK_ACCESS_REGS_VH
`define CLK_PERIOD_PS        5000
`define TICK_PERIOD_MS       10
`define TICK_CYCLES          ((`TICK_PERIOD_MS * 1000000) / (`CLK_PERIOD_PS / 1000))
`define KEY_UP_DELAY_RST     7'h19
`define SLOT_TIME_RST        7'h0A
`define MAX_LINK_CHAN_RST    4'h4
`define MAX_LINK_CHAN_LIM    4'hA
`define HANDSHAKE_RST        2'h3
`define ACK_DELAY_RST        16'h0096
`define LINK_IDLE_RST        15'h4650
`define GREETING_RST         2'h0
`define CHAR_WIDTH_RST       1'h1
`define RTT_WEIGHT_ONE_RST   8'h07
`define RTT_WEIGHT_TWO_RST   8'h0F
`define RTT_WEIGHT_THREE_RST 8'h03
`define POLL_LEN_RST         8'h3C
`define PERSIST_RST          8'h20
`define PERSIST_DEMAND_ASSIGNED_ACCESS         8'hFF
`define TX_LIMIT_TICKS       16'h05DC
`define LINE_MAX             7'h50
`define CMD_KEY_UP           4'h0
`define CMD_SLOT             4'h1
`define CMD_XMIT_EN          4'h2
`define CMD_MAX_CHAN         4'h3
`define CMD_HANDSHAKE        4'h4
`define CMD_ACK_DELAY        4'h5
`define CMD_LINK_IDLE        4'h6
`define CMD_GREETING         4'h7
`define CMD_CHAR_WIDTH       4'h8
`define CMD_RTT_ONE          4'h9
`define CMD_RTT_TWO          4'hA
`define CMD_RTT_THREE        4'hB
`define CMD_POLL_LEN         4'hC
`define CMD_ID_CHECK         4'hD
`define CMD_PERSIST          4'hE
`endif

// [dv/link_partner.sv]
// shared carrier-detect line and far station model
`timescale 1ns/100ps
`default_nettype none
module link_partner (
	input  wire dcd_oe,
	input  wire other_pull,
	input  wire far_sig,
	output wire line_n,
	output wire own_sig
);
	// ====
	// pulled-up wired-or line, low while any unit pulls it
	assign line_n = !(dcd_oe | other_pull);
	// demodulator sees our rate only while the far end keys
	assign own_sig = far_sig;
endmodule
`default_nettype wire

// [dv/packet_link_access_control_chk.sv]
// assertion checker for the link access controller
`timescale 1ns/100ps
`default_nettype none
module link_access_chk (
	input wire       clk,
	input wire       rstn,
	input wire       clk_en,
	input wire       own_signal_detect,
	input wire       shared_dcd_n_in,
	input wire       bit_error_test,
	input wire       data_bit,
	input wire [3:0] channel_select,
	input wire       ptt_r,
	input wire       tx_data_ok_r,
	input wire       tx_bit_r,
	input wire       shared_dcd_oe_r,
	input wire       shared_dcd_out_r,
	input wire       carrier_led_r,
	input wire       chan_ok_r,
	input wire       xmit_enable_r,
	input wire [3:0] max_link_channels_r,
	input wire [1:0] handshake_r,
	input wire       xon_to_term_r,
	input wire       xon_to_ctrl_r
);
	// ====
	// one domain, so clock and reset are given once
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence s_key_up;
		$rose(ptt_r);
	endsequence
	sequence s_data_go;
		$rose(tx_data_ok_r);
	endsequence
	chk_xmit_gate: assert property (s_key_up |-> $past(xmit_enable_r))
		else $error("keyed while disabled");
	chk_data_keyed: assert property (s_data_go |-> ptt_r)
		else $error("data without keying");
	chk_dcd_pull: assert property (clk_en |=> shared_dcd_oe_r == $past(own_signal_detect))
		else $error("shared line pull wrong");
	chk_dcd_low: assert property (shared_dcd_oe_r |-> !shared_dcd_out_r)
		else $error("shared line driven high");
	chk_busy_led: assert property (clk_en |=>
		carrier_led_r == (!$past(shared_dcd_n_in) || $past(own_signal_detect)))
		else $error("carrier indicator wrong");
	chk_ber_zeros: assert property (clk_en |=>
		tx_bit_r == ($past(data_bit) && !$past(bit_error_test)))
		else $error("transmit bit wrong");
	chk_chan_range: assert property (clk_en |=>
		chan_ok_r == ($past(channel_select) != 4'h0
		&& $past(channel_select) <= $past(max_link_channels_r)))
		else $error("channel check wrong");
	chk_xon_map: assert property (clk_en |=>
		{xon_to_term_r, xon_to_ctrl_r} == $past(handshake_r))
		else $error("handshake split wrong");
endmodule
bind packet_link_access_control link_access_chk u_chk (.*);
`default_nettype wire

// [dv/tb_top.sv]
// self-checking bench for the link access controller
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	// ====
	// short tick keeps timer runs brief
	localparam TK = 10;
	reg clk = 0, rstn = 0, clk_en = 1, cmd_valid = 0, tx_request = 0, rx_packet_done = 0;
	reg remote_activity = 0, remote_connect = 0, terminal_mode = 0, term_char_valid = 0;
	reg rx_active = 0, mute_off_strap = 0, bit_error_test = 0, limit_off_strap = 0;
	reg demand_assigned_access = 0, data_bit = 0, other_pull = 0, far_sig = 0;
	reg [3:0] cmd_sel = 4'h0, channel_select = 4'h0;
	reg [15:0] cmd_data = 16'h0000, d;
	reg [7:0] term_char = 8'h00, random_byte = 8'h01, q[$], hq[$];
	wire own_signal_detect, shared_dcd_n_in, ptt_r, tx_data_ok_r, tx_bit_r, shared_dcd_oe_r;
	wire shared_dcd_out_r, carrier_led_r, ack_send_r, status_poll_r, greeting_send_r;
	wire disconnect_r, limit_trip_r, chan_ok_r, xon_to_term_r, xon_to_ctrl_r, char_width_8_r;
	wire id_check_r, xmit_enable_r, line_hidden_r, line_clear_r;
	wire [6:0] key_up_delay_r, slot_time_r, line_len_r;
	wire [3:0] max_link_channels_r;
	wire [1:0] handshake_r, greeting_mode_r;
	wire [15:0] ack_delay_timer_r;
	wire [14:0] link_idle_timer_r;
	wire [7:0] rtt_weight_one_r, rtt_weight_two_r, rtt_weight_three_r, poll_frame_len_r;
	wire [7:0] persistence_value_r;
	integer miscompares = 0, total_checks = 0, c, c2, s, dsc = 0, hid = 0;
	integer wd[15] = '{7, 7, 1, 4, 2, 16, 15, 2, 1, 8, 8, 8, 8, 1, 8};
	packet_link_access_control #(.TICK_CYCLES(TK)) u_packet_link_access_control (.*);
	link_partner u_link_partner (.dcd_oe(shared_dcd_oe_r), .other_pull(other_pull),
		.far_sig(far_sig), .line_n(shared_dcd_n_in), .own_sig(own_signal_detect));
	initial forever #2.5 clk = !clk;
	// random data, draw and channel, 1 ns after each rising edge
	always @(posedge clk) begin
		#1;
		data_bit = $urandom;
		bit_error_test = $urandom;
		channel_select = $urandom;
		random_byte = $urandom % 255 + 1; // never zero, so persistence 0 never keys
	end
	function [15:0] fld(input integer k);
		case (k)
		0: fld = key_up_delay_r;
		1: fld = slot_time_r;
		2: fld = xmit_enable_r;
		3: fld = max_link_channels_r;
		4: fld = handshake_r;
		5: fld = ack_delay_timer_r;
		6: fld = link_idle_timer_r;
		7: fld = greeting_mode_r;
		8: fld = char_width_8_r;
		9: fld = rtt_weight_one_r;
		10: fld = rtt_weight_two_r;
		11: fld = rtt_weight_three_r;
		12: fld = poll_frame_len_r;
		13: fld = id_check_r;
		default: fld = persistence_value_r;
		endcase
	endfunction
	function sel(input integer w);
		case (w)
		0: sel = ptt_r;
		1: sel = tx_data_ok_r;
		2: sel = ack_send_r;
		3: sel = status_poll_r;
		4: sel = greeting_send_r;
		default: sel = limit_trip_r;
		endcase
	endfunction
	task wrap_up;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task cmp(input string nm, input [15:0] e, input [15:0] g);
		total_checks++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %s expected %0h seen %0h", nm, e, g);
		end
	endtask
	task rng(input string nm, input integer lo, input integer hi, input integer g);
		total_checks++;
		if (g < lo || g > hi) begin
			miscompares++;
			$display("[FAIL] %s expected %0d..%0d seen %0d", nm, lo, hi, g);
		end
	endtask
	task step(input integer k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task wr(input integer k, input [15:0] v);
		cmd_sel = k[3:0];
		cmd_data = v;
		cmd_valid = 1;
		step(1);
		cmd_valid = 0;
		step(1);
	endtask
	// bounded wait for an output; a required event that never comes ends the run
	task wt(input integer w, input integer lim, input integer must, output integer n);
		n = 0;
		while (sel(w) !== 1'b1 && n < lim) begin
			step(1);
			n++;
		end
		if (must && n >= lim) begin
			miscompares++;
			wrap_up;
		end
	endtask
	task txt(input integer e);
		tx_request = 1;
		wt(0, 80, e, c);
		cmp("keyed", e, c < 80);
		tx_request = 0;
		step(3);
	endtask
	task conn(input integer e);
		remote_connect = 1;
		step(1);
		remote_connect = 0;
		wt(4, 30, e, c);
		cmp("greet", e, c < 30);
	endtask
	// one typed character against the queue model of the line
	task ty(input [7:0] ch);
		term_char = ch;
		term_char_valid = 1;
		step(1);
		term_char_valid = 0;
		dsc = dsc | disconnect_r;
		cmp("clear", ch == 8'h15 || ch == 8'h18, line_clear_r);
		if (ch == 8'h08 || ch == 8'h7F) begin
			if (q.size() > 0)
				q.pop_back();
		end else if (ch == 8'h15 || ch == 8'h18)
			q.delete();
		else if (ch == 8'h12) begin
			if (hid == 0) begin
				hq = q;
				q.delete();
			end else
				q = hq;
			hid = !hid;
		end else
			q.push_back(ch);
		step(1);
		dsc = dsc | disconnect_r;
		cmp("len", q.size(), line_len_r);
		cmp("hide", hid, line_hidden_r);
	endtask
	initial begin
		c = $urandom(39);
		step(12);
		rstn = 1;
		cmp("key_slot", {key_up_delay_r, slot_time_r}, {7'h19, 7'h0A});
		cmp("chan_hs", {max_link_channels_r, handshake_r, xmit_enable_r}, {4'h4, 2'h3, 1'h1});
		cmp("ack", ack_delay_timer_r, 16'h0096);
		cmp("idle", link_idle_timer_r, 15'h4650);
		cmp("greet_cw", {greeting_mode_r, char_width_8_r}, {2'h0, 1'h1});
		cmp("rtt", {rtt_weight_one_r, rtt_weight_two_r}, {8'h07, 8'h0F});
		cmp("rtt_poll", {rtt_weight_three_r, poll_frame_len_r}, {8'h03, 8'h3C});
		cmp("id_pers", {id_check_r, persistence_value_r}, {1'h0, 8'h20});
		// ====
		// every field written back to back with a random value
		for (s = 0; s < 15; s++) begin
			d = $urandom & ((1 << wd[s]) - 1);
			if (s == 3)
				d = d % 11;
			wr(s, d);
			cmp("field", d, fld(s));
		end
		wr(0, 3);
		wr(1, 2);
		wr(2, 1);
		wr(14, 0);
		txt(0);
		demand_assigned_access = 1;
		txt(1);
		demand_assigned_access = 0;
		wr(14, 16'h00FF);
		wr(2, 0);
		txt(0);
		wr(2, 1);
		other_pull = 1;
		txt(0);
		cmp("led", 1, carrier_led_r);
		other_pull = 0;
		far_sig = 1;
		txt(0);
		far_sig = 0;
		rx_active = 1;
		txt(0);
		mute_off_strap = 1;
		txt(1);
		rx_active = 0;
		// ====
		// slot, key-up and limiter timing in ticks
		tx_request = 1;
		wt(0, 200, 1, c);
		rng("slot", TK, 2 * TK + 4, c);
		wt(1, 200, 1, c);
		rng("key_up", 2 * TK, 3 * TK + 3, c);
		wt(5, 16000, 1, c2);
		rng("limit", 1490 * TK, 1503 * TK, c + c2);
		step(1);
		cmp("unkey", 0, ptt_r);
		tx_request = 0;
		step(2);
		// strap on: keying must outlast the limit without a trip
		limit_off_strap = 1;
		tx_request = 1;
		wt(5, 15600, 0, c2);
		cmp("no_trip", 0, limit_trip_r);
		cmp("held", 1, ptt_r);
		tx_request = 0;
		wr(5, 3);
		limit_off_strap = 0;
		rx_packet_done = 1;
		step(1);
		rx_packet_done = 0;
		wt(2, 100, 1, c);
		rng("ack", 2 * TK, 3 * TK + 3, c);
		wr(6, 2);
		remote_activity = 1;
		step(1);
		remote_activity = 0;
		wt(3, 100, 1, c);
		rng("poll", TK, 2 * TK + 3, c);
		// ====
		// greeting, quit sequence and line editing
		wr(7, 0);
		conn(0);
		wr(7, 1);
		conn(1);
		wr(7, 2);
		terminal_mode = 1;
		ty(8'h15);
		ty("/");
		ty("/");
		ty("Q");
		ty(8'h18);
		cmp("quit", 1, dsc);
		ty("a");
		ty("b");
		ty(8'h08);
		ty(8'h7F);
		ty(8'h08);
		ty("x");
		ty(8'h12);
		ty(8'h12);
		ty(8'h15);
		wrap_up;
	end
endmodule
`default_nettype wire
